/* plss_core.sv */
// What this block does
// - the watchdog counts on pclk, the oscillator, not the loop output.
// - with no loop edges the enabled watchdog expires, and resets only if its reset enable bit is set.
// - on the earliest revision a zero multiplier breaks the loop.
// - bypass is by clearing clock enable, never a zero multiplier.
// - lock done may set although the loop makes no clock.
// - a dead loop chosen as cpu clock halts instruction execution.
module plss_core
   import plss_pkg::*;
#(
   parameter int LOCK_CNT = PLSS_LOCK_CNT_DEF,
   parameter int WDG_CNT = PLSS_WDG_CNT_DEF,
   parameter int EDGE_TMO = PLSS_EDGE_TMO_DEF,
   parameter bit EARLY_REV = 1'b1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sys_loop_toggle,
   input wire logic usb_loop_toggle,
   input wire logic wdg_kick,
   output logic loop_system_clock_sel,
   output logic system_loop_clock_enable,
   output logic usb_loop_clock_enable,
   output logic [PLSS_MULT_W-1:0] system_loop_multiplier,
   output logic [PLSS_MULT_W-1:0] usb_loop_multiplier,
   output logic cpu_halt,
   output logic wdg_reset_req,
   output logic irq
);
   localparam int LW = $clog2(LOCK_CNT + 1);
   localparam int WW = $clog2(WDG_CNT + 1);
   localparam int EW = $clog2(EDGE_TMO + 1);
   localparam logic [LW-1:0] LOCK_TOP = LW'(LOCK_CNT);
   localparam logic [WW-1:0] WDG_TOP = WW'(WDG_CNT);
   localparam logic [EW-1:0] EDGE_TOP = EW'(EDGE_TMO);

   typedef enum logic [2:0] {
      PLSS_L_OFF = 3'b001,
      PLSS_L_LOCKING = 3'b010,
      PLSS_L_DONE = 3'b100
   } plss_lstate_t;

   // ---------------------------------------------------------------
   // loop edge synchronisers (loop clocks seen as toggles)
   // ---------------------------------------------------------------
   logic [2:0] sys_sync_reg, usb_sync_reg;
   logic [2:0] sys_sync_next, usb_sync_next;
   logic sys_edge, usb_edge;

   always_comb begin
      sys_sync_next = {sys_sync_reg[1:0], sys_loop_toggle};
      usb_sync_next = {usb_sync_reg[1:0], usb_loop_toggle};
      // stage 0 is read only by stage 1
      sys_edge = sys_sync_reg[2] ^ sys_sync_reg[1];
      usb_edge = usb_sync_reg[2] ^ usb_sync_reg[1];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_sync_reg <= 3'h0;
         usb_sync_reg <= 3'h0;
      end else begin
         sys_sync_reg <= sys_sync_next;
         usb_sync_reg <= usb_sync_next;
      end
   end

   // ---------------------------------------------------------------
   // register state
   // ---------------------------------------------------------------
   plss_loop_ctl_t sys_ctl_reg, sys_ctl_next, usb_ctl_reg, usb_ctl_next;
   logic [PLSS_MULT_W-1:0] sys_mult_reg, sys_mult_next;
   logic [PLSS_MULT_W-1:0] usb_mult_reg, usb_mult_next;
   logic wdg_en_reg, wdg_en_next, wdg_rsten_reg, wdg_rsten_next;
   logic clksel_reg, clksel_next;
   logic [PLSS_IRQ_W-1:0] irq_sts_reg, irq_sts_next;
   logic [PLSS_IRQ_W-1:0] irq_mask_reg, irq_mask_next;
   logic wdg_cause_reg, wdg_cause_next;
   logic [31:0] prdata_reg, prdata_next;
   plss_lstate_t sys_st_reg, sys_st_next, usb_st_reg, usb_st_next;
   logic [LW-1:0] sys_lcnt_reg, sys_lcnt_next, usb_lcnt_reg, usb_lcnt_next;
   logic [EW-1:0] sys_ecnt_reg, sys_ecnt_next, usb_ecnt_reg, usb_ecnt_next;
   logic [WW-1:0] wdg_cnt_reg, wdg_cnt_next;
   logic wdg_rst_reg, wdg_rst_next;
   plss_loop_sts_t sys_sts, usb_sts;
   logic wr, rd, mapped;
   logic [PLSS_IRQ_W-1:0] ev;

   function automatic logic addr_hit(input logic [7:0] a,
                                     input logic [7:0] r);
      return a == r;
   endfunction

   assign wr = psel && penable && pwrite;
   // read word loaded in setup so it stands at the completing edge
   assign rd = psel && !penable && !pwrite;

   // a loop counts as running while edges are seen, whatever its enable or multiplier
   always_comb begin
      sys_sts.lock_counter_done = (sys_st_reg == PLSS_L_DONE);
      sys_sts.loop_running = (sys_ecnt_reg != EDGE_TOP);
      usb_sts.lock_counter_done = (usb_st_reg == PLSS_L_DONE);
      usb_sts.loop_running = (usb_ecnt_reg != EDGE_TOP);
   end

   // ---------------------------------------------------------------
   // lock counters: done says nothing about real edges
   // ---------------------------------------------------------------
   function automatic plss_lstate_t lock_step(input plss_lstate_t s,
                                              input plss_loop_ctl_t c,
                                              input logic cnt_top);
      plss_lstate_t n;
      n = s;
      case (s)
         PLSS_L_OFF: if (c.lock_go) n = PLSS_L_LOCKING;
         PLSS_L_LOCKING: if (!c.lock_go) n = PLSS_L_OFF;
                         else if (cnt_top) n = PLSS_L_DONE;
         PLSS_L_DONE: if (!c.lock_go) n = PLSS_L_OFF;
         default: n = PLSS_L_OFF;
      endcase
      return n;
   endfunction

   always_comb begin
      sys_st_next = lock_step(sys_st_reg, sys_ctl_reg,
                              sys_lcnt_reg == LOCK_TOP);
      usb_st_next = lock_step(usb_st_reg, usb_ctl_reg,
                              usb_lcnt_reg == LOCK_TOP);
      sys_lcnt_next = (sys_st_reg == PLSS_L_LOCKING) ?
                      sys_lcnt_reg + LW'(1) : '0;
      usb_lcnt_next = (usb_st_reg == PLSS_L_LOCKING) ?
                      usb_lcnt_reg + LW'(1) : '0;
      // edge watchdogs saturate when a loop stays silent
      sys_ecnt_next = sys_edge ? '0 :
                      (sys_ecnt_reg == EDGE_TOP) ? sys_ecnt_reg :
                      sys_ecnt_reg + EW'(1);
      usb_ecnt_next = usb_edge ? '0 :
                      (usb_ecnt_reg == EDGE_TOP) ? usb_ecnt_reg :
                      usb_ecnt_reg + EW'(1);
   end

   // ---------------------------------------------------------------
   // watchdog on pclk, independent of any loop output
   // ---------------------------------------------------------------
   always_comb begin
      wdg_cnt_next = '0;
      wdg_rst_next = 1'b0;
      if (wdg_en_reg && !wdg_kick) begin
         if (wdg_cnt_reg == WDG_TOP)
            wdg_rst_next = wdg_rsten_reg;
         else
            wdg_cnt_next = wdg_cnt_reg + WW'(1);
      end
   end

   // ---------------------------------------------------------------
   // apb register file
   // ---------------------------------------------------------------
   always_comb begin
      sys_ctl_next = sys_ctl_reg;
      usb_ctl_next = usb_ctl_reg;
      sys_mult_next = sys_mult_reg;
      usb_mult_next = usb_mult_reg;
      wdg_en_next = wdg_en_reg;
      wdg_rsten_next = wdg_rsten_reg;
      clksel_next = clksel_reg;
      irq_mask_next = irq_mask_reg;
      wdg_cause_next = wdg_cause_reg;
      prdata_next = prdata_reg;
      mapped = 1'b1;
      ev = '0;
      ev[PLSS_IRQ_SYS_LOCK] = (sys_st_reg == PLSS_L_LOCKING) &&
                              (sys_st_next == PLSS_L_DONE);
      ev[PLSS_IRQ_USB_LOCK] = (usb_st_reg == PLSS_L_LOCKING) &&
                              (usb_st_next == PLSS_L_DONE);
      irq_sts_next = irq_sts_reg;
      if (wr && addr_hit(paddr, PLSS_IRQ_STS_ADDR))
         irq_sts_next = irq_sts_reg & ~pwdata[PLSS_IRQ_W-1:0];
      case (paddr)
         PLSS_SYS_CTL_ADDR, PLSS_USB_CTL_ADDR, PLSS_SYS_MULT_ADDR,
         PLSS_USB_MULT_ADDR, PLSS_STS_ADDR, PLSS_WDG_CTL_ADDR,
         PLSS_CLKSEL_ADDR, PLSS_IRQ_STS_ADDR, PLSS_IRQ_MASK_ADDR,
         PLSS_RST_CAUSE_ADDR: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
      if (wr) begin
         case (paddr)
            PLSS_SYS_CTL_ADDR: begin
               sys_ctl_next.clk_enable = pwdata[PLSS_CTL_CLKEN_BIT];
               sys_ctl_next.lock_go = pwdata[PLSS_CTL_LOCKGO_BIT];
            end
            PLSS_USB_CTL_ADDR: begin
               usb_ctl_next.clk_enable = pwdata[PLSS_CTL_CLKEN_BIT];
               usb_ctl_next.lock_go = pwdata[PLSS_CTL_LOCKGO_BIT];
            end
            PLSS_SYS_MULT_ADDR: begin
               sys_mult_next = pwdata[PLSS_MULT_W-1:0];
               ev[PLSS_IRQ_ZERO_MULT] =
                  (pwdata[PLSS_MULT_W-1:0] == PLSS_MULT_ZERO);
            end
            PLSS_USB_MULT_ADDR: begin
               usb_mult_next = pwdata[PLSS_MULT_W-1:0];
               ev[PLSS_IRQ_ZERO_MULT] =
                  (pwdata[PLSS_MULT_W-1:0] == PLSS_MULT_ZERO);
            end
            PLSS_WDG_CTL_ADDR: begin
               wdg_en_next = pwdata[PLSS_WDG_EN_BIT];
               wdg_rsten_next = pwdata[PLSS_WDG_RSTEN_BIT];
            end
            PLSS_CLKSEL_ADDR: clksel_next = pwdata[0];
            PLSS_IRQ_MASK_ADDR: irq_mask_next = pwdata[PLSS_IRQ_W-1:0];
            PLSS_RST_CAUSE_ADDR: if (pwdata[0]) wdg_cause_next = 1'b0;
            default: ;
         endcase
      end
      if (rd) begin
         prdata_next = PLSS_ZERO32;
         case (paddr)
            PLSS_SYS_CTL_ADDR: prdata_next[1:0] = sys_ctl_reg;
            PLSS_USB_CTL_ADDR: prdata_next[1:0] = usb_ctl_reg;
            PLSS_SYS_MULT_ADDR:
               prdata_next[PLSS_MULT_W-1:0] = sys_mult_reg;
            PLSS_USB_MULT_ADDR:
               prdata_next[PLSS_MULT_W-1:0] = usb_mult_reg;
            PLSS_STS_ADDR: prdata_next[3:0] = {usb_sts, sys_sts};
            PLSS_WDG_CTL_ADDR:
               prdata_next[1:0] = {wdg_rsten_reg, wdg_en_reg};
            PLSS_CLKSEL_ADDR: prdata_next[0] = clksel_reg;
            PLSS_IRQ_STS_ADDR: prdata_next[PLSS_IRQ_W-1:0] = irq_sts_reg;
            PLSS_IRQ_MASK_ADDR:
               prdata_next[PLSS_IRQ_W-1:0] = irq_mask_reg;
            PLSS_RST_CAUSE_ADDR: prdata_next[0] = wdg_cause_reg;
            default: ;
         endcase
      end
      // set beats clear
      irq_sts_next = irq_sts_next | ev;
      // watchdog reset: clock back to oscillator, both loops disabled
      if (wdg_rst_reg) begin
         clksel_next = 1'b0;
         sys_ctl_next = '0;
         usb_ctl_next = '0;
         wdg_en_next = 1'b0;
         wdg_rsten_next = 1'b0;
         wdg_cause_next = 1'b1;
         irq_sts_next[PLSS_IRQ_WDG_RST] = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_ctl_reg <= '0;
         usb_ctl_reg <= '0;
         sys_mult_reg <= PLSS_MULT_RST;
         usb_mult_reg <= PLSS_MULT_RST;
         wdg_en_reg <= 1'b0;
         wdg_rsten_reg <= 1'b0;
         clksel_reg <= 1'b0;
         irq_sts_reg <= '0;
         irq_mask_reg <= '0;
         wdg_cause_reg <= 1'b0;
         prdata_reg <= PLSS_ZERO32;
         sys_st_reg <= PLSS_L_OFF;
         usb_st_reg <= PLSS_L_OFF;
         sys_lcnt_reg <= '0;
         usb_lcnt_reg <= '0;
         // silent until a first loop edge is seen
         sys_ecnt_reg <= EDGE_TOP;
         usb_ecnt_reg <= EDGE_TOP;
         wdg_cnt_reg <= '0;
         wdg_rst_reg <= 1'b0;
      end else begin
         sys_ctl_reg <= sys_ctl_next;
         usb_ctl_reg <= usb_ctl_next;
         sys_mult_reg <= sys_mult_next;
         usb_mult_reg <= usb_mult_next;
         wdg_en_reg <= wdg_en_next;
         wdg_rsten_reg <= wdg_rsten_next;
         clksel_reg <= clksel_next;
         irq_sts_reg <= irq_sts_next;
         irq_mask_reg <= irq_mask_next;
         wdg_cause_reg <= wdg_cause_next;
         prdata_reg <= prdata_next;
         sys_st_reg <= sys_st_next;
         usb_st_reg <= usb_st_next;
         sys_lcnt_reg <= sys_lcnt_next;
         usb_lcnt_reg <= usb_lcnt_next;
         sys_ecnt_reg <= sys_ecnt_next;
         usb_ecnt_reg <= usb_ecnt_next;
         wdg_cnt_reg <= wdg_cnt_next;
         wdg_rst_reg <= wdg_rst_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // zero multiplier on early silicon: loop treated as not enabled
   assign system_loop_clock_enable = sys_ctl_reg.clk_enable &&
      !(EARLY_REV && sys_mult_reg == PLSS_MULT_ZERO);
   assign usb_loop_clock_enable = usb_ctl_reg.clk_enable &&
      !(EARLY_REV && usb_mult_reg == PLSS_MULT_ZERO);
   assign system_loop_multiplier = sys_mult_reg;
   assign usb_loop_multiplier = usb_mult_reg;
   assign loop_system_clock_sel = clksel_reg;
   // loop selected but silent: cpu stalls until watchdog fires
   assign cpu_halt = clksel_reg && !sys_sts.loop_running;
   assign wdg_reset_req = wdg_rst_reg;
   assign irq = |(irq_sts_reg & irq_mask_reg);
   assign prdata = prdata_reg;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
endmodule

/* plss_core_asserts.sv */
module plss_core_asserts
   import plss_pkg::*;
#(
   parameter int EDGE_TMO = PLSS_EDGE_TMO_DEF,
   parameter bit EARLY_REV = 1'b1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pslverr,
   input wire logic sys_loop_toggle,
   input wire logic wdg_kick,
   input wire logic loop_system_clock_sel,
   input wire logic system_loop_clock_enable,
   input wire logic usb_loop_clock_enable,
   input wire logic [PLSS_MULT_W-1:0] system_loop_multiplier,
   input wire logic [PLSS_MULT_W-1:0] usb_loop_multiplier,
   input wire logic cpu_halt,
   input wire logic wdg_reset_req
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ---------------------------------------------------------------
   // quiet time of the system loop toggle
   // ---------------------------------------------------------------
   logic tog_reg;
   int quiet_reg, quiet_next;
   always_comb begin
      quiet_next = (sys_loop_toggle == tog_reg) ? quiet_reg + 1 : 0;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tog_reg <= 1'b0;
         quiet_reg <= 0;
      end else begin
         tog_reg <= sys_loop_toggle;
         quiet_reg <= quiet_next;
      end
   end
   property p_halt_sel;
      cpu_halt |-> loop_system_clock_sel;
   endproperty
   a_halt_sel: assert property (p_halt_sel) else $error("halt off loop");
   // sync stages plus timeout give a few cycles of slack
   property p_halt_dead;
      loop_system_clock_sel && quiet_reg > EDGE_TMO + 6 |-> cpu_halt;
   endproperty
   a_halt_dead: assert property (p_halt_dead) else $error("no halt");
   property p_sys_zero;
      EARLY_REV && system_loop_multiplier == PLSS_MULT_ZERO
         |-> !system_loop_clock_enable;
   endproperty
   a_sys_zero: assert property (p_sys_zero) else $error("sys zero mult");
   property p_usb_zero;
      EARLY_REV && usb_loop_multiplier == PLSS_MULT_ZERO
         |-> !usb_loop_clock_enable;
   endproperty
   a_usb_zero: assert property (p_usb_zero) else $error("usb zero mult");
   property p_wdg_clr;
      wdg_reset_req |=> !loop_system_clock_sel && !system_loop_clock_enable
         && !usb_loop_clock_enable;
   endproperty
   a_wdg_clr: assert property (p_wdg_clr) else $error("not restored");
   property p_wdg_pulse;
      wdg_reset_req |=> !wdg_reset_req;
   endproperty
   a_wdg_pulse: assert property (p_wdg_pulse) else $error("long pulse");
   property p_kick;
      wdg_kick [*3] |-> !wdg_reset_req;
   endproperty
   a_kick: assert property (p_kick) else $error("expired while kicked");
   property p_unmapped;
      psel && penable && paddr > PLSS_RST_CAUSE_ADDR |-> pslverr;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("no slave error");
   c_wdg: cover property (wdg_reset_req);
   c_halt: cover property (cpu_halt);
   c_err: cover property (psel && penable && pslverr);
endmodule

bind plss_core plss_core_asserts #(.EDGE_TMO(EDGE_TMO),
   .EARLY_REV(EARLY_REV)) chk_u (.pclk, .presetn, .psel, .penable,
   .paddr, .pslverr, .sys_loop_toggle, .wdg_kick, .loop_system_clock_sel,
   .system_loop_clock_enable, .usb_loop_clock_enable,
   .system_loop_multiplier, .usb_loop_multiplier, .cpu_halt,
   .wdg_reset_req);

/* plss_core_tb.sv */
module plss_core_tb
   import plss_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int WCNT = 32;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
   logic pwrite = 1'h0, sys_loop_toggle = 1'h0, usb_loop_toggle = 1'h0;
   logic wdg_kick = 1'h0, run_tog = 1'h0, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, loop_system_clock_sel, system_loop_clock_enable;
   logic usb_loop_clock_enable, cpu_halt, wdg_reset_req, irq;
   logic [PLSS_MULT_W-1:0] system_loop_multiplier, usb_loop_multiplier;
   int fail_count = 0, n_tests = 0;
   always #25 pclk = ~pclk;
   always @(posedge pclk) begin
      if (run_tog) begin
         sys_loop_toggle <= ~sys_loop_toggle;
         usb_loop_toggle <= ~usb_loop_toggle;
      end
   end
   plss_core #(.LOCK_CNT(8), .WDG_CNT(WCNT), .EDGE_TMO(8)) dut_u (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .sys_loop_toggle, .usb_loop_toggle, .wdg_kick,
      .loop_system_clock_sel, .system_loop_clock_enable,
      .usb_loop_clock_enable, .system_loop_multiplier,
      .usb_loop_multiplier, .cpu_halt, .wdg_reset_req, .irq);
   // ---------------------------------------------------------------
   // bus and compare helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // read data and slave error taken at the completing edge
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      err = pslverr;
      rd = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
      // idle edge: psel is never driven twice in one step
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'h0, a, PLSS_ZERO32);
      chk(rd, exp);
   endtask
   task automatic poll(input logic [7:0] a, input int b);
      int k;
      k = 0;
      rd = 32'h0;
      while (rd[b] !== 1'h1 && k < 100) begin
         apb(1'h0, a, PLSS_ZERO32);
         k++;
      end
      chk({31'h0, rd[b]}, 32'h1);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      chk({31'h0, pready}, 32'h1);
      chk({25'h0, system_loop_multiplier}, {25'h0, PLSS_MULT_RST});
      rdc(PLSS_USB_MULT_ADDR, {25'h0, PLSS_MULT_RST});
      rdc(PLSS_CLKSEL_ADDR, 32'h0);
      rdc(PLSS_STS_ADDR, 32'h0);
      apb(1'h0, 8'h40, PLSS_ZERO32);
      chk({rd[30:0], err}, 32'h1);
   endtask
   task automatic t_locks();
      for (int i = 0; i < 5; i++) begin
         wr(PLSS_SYS_CTL_ADDR, 32'h1);
         wr(PLSS_SYS_CTL_ADDR, 32'h3);
         poll(PLSS_STS_ADDR, 1);
         wr(PLSS_USB_CTL_ADDR, 32'h1);
         wr(PLSS_USB_CTL_ADDR, 32'h3);
         poll(PLSS_STS_ADDR, 3);
      end
      chk({30'h0, rd[1:0]}, 32'h2);
      chk({30'h0, rd[3:2]}, 32'h2);
      chk({31'h0, system_loop_clock_enable}, 32'h1);
      chk({31'h0, irq}, 32'h0);
      wr(PLSS_IRQ_MASK_ADDR, 32'h3);
      chk({31'h0, irq}, 32'h1);
      wr(PLSS_IRQ_STS_ADDR, 32'h3);
      chk({31'h0, irq}, 32'h0);
      wr(PLSS_IRQ_MASK_ADDR, 32'h0);
   endtask
   task automatic t_wdg();
      int k;
      wr(PLSS_WDG_CTL_ADDR, 32'h3);
      wr(PLSS_CLKSEL_ADDR, 32'h1);
      chk({31'h0, cpu_halt}, 32'h1);
      k = 0;
      while (wdg_reset_req !== 1'h1 && k < WCNT + 40) begin
         @(posedge pclk);
         #1 k++;
      end
      chk({31'h0, k >= WCNT - 4 && k <= WCNT + 4}, 32'h1);
      @(posedge pclk);
      #1 chk({31'h0, loop_system_clock_sel}, 32'h0);
      rdc(PLSS_WDG_CTL_ADDR, 32'h0);
      rdc(PLSS_RST_CAUSE_ADDR, 32'h1);
      rdc(PLSS_IRQ_STS_ADDR, 32'h8);
      wr(PLSS_RST_CAUSE_ADDR, 32'h1);
      rdc(PLSS_RST_CAUSE_ADDR, 32'h0);
      wr(PLSS_IRQ_STS_ADDR, 32'hf);
      run_tog <= 1'h1;
      wdg_kick <= 1'h1;
      wr(PLSS_WDG_CTL_ADDR, 32'h3);
      wr(PLSS_CLKSEL_ADDR, 32'h1);
      k = 0;
      repeat (WCNT + 10) begin
         @(posedge pclk);
         #1;
         if (wdg_reset_req !== 1'h0 || cpu_halt !== 1'h0) k++;
      end
      chk(k, 32'h0);
      rdc(PLSS_STS_ADDR, 32'h5);
      wr(PLSS_CLKSEL_ADDR, 32'h0);
      wr(PLSS_WDG_CTL_ADDR, 32'h0);
      wdg_kick <= 1'h0;
      run_tog <= 1'h0;
   endtask
   task automatic t_mult();
      wr(PLSS_SYS_CTL_ADDR, 32'h1);
      wr(PLSS_SYS_MULT_ADDR, 32'h0);
      chk({31'h0, system_loop_clock_enable}, 32'h0);
      wr(PLSS_SYS_MULT_ADDR, 32'h5);
      chk({31'h0, system_loop_clock_enable}, 32'h1);
      chk({25'h0, system_loop_multiplier}, 32'h5);
      wr(PLSS_SYS_CTL_ADDR, 32'h0);
      chk({31'h0, system_loop_clock_enable}, 32'h0);
      chk({25'h0, system_loop_multiplier}, 32'h5);
      wr(PLSS_USB_CTL_ADDR, 32'h1);
      wr(PLSS_USB_MULT_ADDR, 32'h0);
      chk({31'h0, usb_loop_clock_enable}, 32'h0);
      chk({25'h0, usb_loop_multiplier}, 32'h0);
      rdc(PLSS_IRQ_STS_ADDR, 32'h4);
   endtask
   // outside supervisor resets the device in mid-run
   task automatic t_super();
      wr(PLSS_WDG_CTL_ADDR, 32'h3);
      wr(PLSS_CLKSEL_ADDR, 32'h1);
      chk({31'h0, cpu_halt}, 32'h1);
      presetn <= 1'h0;
      repeat (2) @(posedge pclk);
      chk({31'h0, loop_system_clock_sel}, 32'h0);
      chk({25'h0, usb_loop_multiplier}, {25'h0, PLSS_MULT_RST});
      presetn <= 1'h1;
      @(posedge pclk);
      rdc(PLSS_WDG_CTL_ADDR, 32'h0);
      rdc(PLSS_USB_CTL_ADDR, 32'h0);
      chk({31'h0, usb_loop_clock_enable}, 32'h0);
      chk({31'h0, cpu_halt}, 32'h0);
   endtask
   task automatic results();
      $display("tests=%0d errors=%0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // a full run needs well under 2000 cycles
   initial begin
      #(50 * 5000);
      fail_count++;
      results();
   end
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      t_reset();
      t_locks();
      t_wdg();
      t_mult();
      t_super();
      results();
   end
endmodule

/* plss_pkg.sv */
package plss_pkg;
   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] PLSS_SYS_CTL_ADDR = 8'h00;
   localparam logic [7:0] PLSS_USB_CTL_ADDR = 8'h04;
   localparam logic [7:0] PLSS_SYS_MULT_ADDR = 8'h08;
   localparam logic [7:0] PLSS_USB_MULT_ADDR = 8'h0c;
   localparam logic [7:0] PLSS_STS_ADDR = 8'h10;
   localparam logic [7:0] PLSS_WDG_CTL_ADDR = 8'h14;
   localparam logic [7:0] PLSS_CLKSEL_ADDR = 8'h18;
   localparam logic [7:0] PLSS_IRQ_STS_ADDR = 8'h1c;
   localparam logic [7:0] PLSS_IRQ_MASK_ADDR = 8'h20;
   localparam logic [7:0] PLSS_RST_CAUSE_ADDR = 8'h24;
   // ---------------------------------------------------------------
   // fields
   // ---------------------------------------------------------------
   localparam int PLSS_MULT_W = 7;
   localparam logic [PLSS_MULT_W-1:0] PLSS_MULT_RST = 7'h01;
   localparam logic [PLSS_MULT_W-1:0] PLSS_MULT_ZERO = 7'h00;
   localparam int PLSS_CTL_CLKEN_BIT = 0;
   localparam int PLSS_CTL_LOCKGO_BIT = 1;
   localparam int PLSS_WDG_EN_BIT = 0;
   localparam int PLSS_WDG_RSTEN_BIT = 1;
   localparam int PLSS_IRQ_W = 4;
   localparam int PLSS_IRQ_SYS_LOCK = 0;
   localparam int PLSS_IRQ_USB_LOCK = 1;
   localparam int PLSS_IRQ_ZERO_MULT = 2;
   localparam int PLSS_IRQ_WDG_RST = 3;
   localparam logic [31:0] PLSS_ZERO32 = 32'h0000_0000;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int PLSS_LOCK_CNT_DEF = 1024;
   localparam int PLSS_WDG_CNT_DEF = 65536;
   localparam int PLSS_EDGE_TMO_DEF = 64;

   typedef struct packed {
      logic clk_enable;
      logic lock_go;
   } plss_loop_ctl_t;

   typedef struct packed {
      logic lock_counter_done;
      logic loop_running;
   } plss_loop_sts_t;
endpackage
